// file: hdl/ess_pkg.sv
// constants, field layouts and carrier types of the external scale status encoder
// assumes one system clock; register offsets are byte addresses on a 32-bit AXI4-Lite bus
package ess_pkg;

   localparam int ESS_ADDR_W = 8;
   localparam int ESS_DATA_W = 32;
   localparam int ESS_TYPE_W_MAX = 8;
   localparam int ESS_SYNC_STAGES = 2;

   // register byte offsets
   localparam logic [7:0] ESS_OFS_CTRL = 8'h00;
   localparam logic [7:0] ESS_OFS_STATUS = 8'h04;
   localparam logic [7:0] ESS_OFS_IRQ_STAT = 8'h08;
   localparam logic [7:0] ESS_OFS_IRQ_CLR = 8'h0c;
   localparam logic [7:0] ESS_OFS_IRQ_EN = 8'h10;

   // control register fields
   localparam int ESS_CTRL_FAMILY_BIT = 0;
   localparam int ESS_CTRL_EXP_TYPE_LSB = 8;
   // status register fields
   localparam int ESS_STAT_LO_LSB = 0;
   localparam int ESS_STAT_HI_LSB = 8;
   localparam int ESS_STAT_TYPE_LSB = 16;

   // status byte bit positions
   localparam int ESS_HI_ERR_SUM_BIT = 5;
   localparam int ESS_HI_ALM_SUM_BIT = 4;
   localparam int ESS_LO_MISMATCH_BIT = 2;

   // interrupt event bits
   localparam int ESS_IRQ_W = 3;
   localparam int ESS_IRQ_ERR_SUM = 0;
   localparam int ESS_IRQ_ALM_SUM = 1;
   localparam int ESS_IRQ_MISMATCH = 2;

   // reset values
   localparam logic ESS_RST_FAMILY = 1'b0;
   localparam logic [7:0] ESS_RST_EXP_TYPE = 8'h00;
   localparam logic [2:0] ESS_RST_IRQ_EN = 3'h0;

   localparam logic [1:0] ESS_RESP_OKAY = 2'h0;
   localparam logic [1:0] ESS_RESP_SLVERR = 2'h2;

   typedef enum logic {
      ESS_FAM_A = 1'b0,
      ESS_FAM_B = 1'b1
   } ess_family_t;

   // first family flags, msb first so the struct is the low status byte
   typedef struct packed {
      logic thermal_alarm;
      logic sig_int_alarm;
      logic sig_int_err;
      logic transducer_err;
      logic abs_det_err;
      logic hw_err;
      logic init_err;
      logic over_speed;
   } ess_fam_a_flags_t;

   typedef struct packed {
      logic thermal_alarm;
      logic comm_err;
      logic cpu_mem_err;
      logic cap_photo_err;
      logic init_err;
      logic over_speed;
   } ess_fam_b_flags_t;

   typedef struct packed {
      logic [7:0] hi;
      logic [7:0] lo;
   } ess_status_t;

endpackage

// file: hdl/ess_encoder.sv
// external scale status encoder: builds the low and high status bytes for two scale families
// assumes scale flags and encoder type arrive asynchronously from the scale interface
// and that software reaches the control and interrupt registers over AXI4-Lite
`timescale 1ns/1ps

// Notes on behaviour
// - family A high bit 5 is the OR of low bits 0 to 5.
// - family A high bit 4 is the OR of thermal and intensity alarms.
// - family A high bits 7, 6 and 3 to 0 are always zero.
// - family B low bits: comm 5, cpu/memory 4, cap/photo 3, init 1, speed 0.
// - family B low bit 2 flags an encoder type differing from the expected one.
// - family B low bit 7 is thermal alarm, low bit 6 is zero.
// - family B high bit 5 error summary, bit 4 alarm summary, rest zero.
module ess_encoder
#(
   parameter int TYPE_W = 8
)
(
   input wire logic mclk,
   input wire logic reset,
   input wire ess_pkg::ess_fam_a_flags_t fam_a_flags,
   input wire ess_pkg::ess_fam_b_flags_t fam_b_flags,
   input wire logic [TYPE_W-1:0] enc_type,
   output ess_pkg::ess_status_t status,
   output logic irq,
   input wire logic [ess_pkg::ESS_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [ess_pkg::ESS_DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ess_pkg::ESS_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [ess_pkg::ESS_DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import ess_pkg::*;

   localparam int RAW_W = 8 + 6 + TYPE_W;

   generate
      if (TYPE_W < 1 || TYPE_W > ESS_TYPE_W_MAX)
      begin : g_bad_type_w
         $error("ess_encoder: TYPE_W must lie between 1 and 8");
      end
   endgenerate

   // input synchroniser, one pair of flops per bit
   wire logic [RAW_W-1:0] raw_in;
   logic [RAW_W-1:0] sync1_q;
   logic [RAW_W-1:0] sync2_q;

   assign raw_in = {enc_type, fam_b_flags, fam_a_flags};

   genvar gi;
   generate
      for (gi = 0; gi < RAW_W; gi++)
      begin : g_sync
         always_ff @(posedge mclk or posedge reset)
         begin
            if (reset)
            begin
               sync1_q[gi] <= 1'b0;
               sync2_q[gi] <= 1'b0;
            end
            else
            begin
               sync1_q[gi] <= raw_in[gi];
               sync2_q[gi] <= sync1_q[gi];
            end
         end
      end
   endgenerate

   wire ess_fam_a_flags_t a_s;
   wire ess_fam_b_flags_t b_s;
   wire logic [TYPE_W-1:0] type_s;

   assign a_s = sync2_q[7:0];
   assign b_s = sync2_q[13:8];
   assign type_s = sync2_q[RAW_W-1:14];

   // the type code is a word from another domain whose bits may land on different edges,
   // so a code is believed only after two equal samples; a skew beyond one clock still slips
   logic [TYPE_W-1:0] type_prev_q;
   logic [TYPE_W-1:0] type_q;
   wire logic type_steady;
   assign type_steady = type_s == type_prev_q;

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         type_prev_q <= '0;
         type_q <= '0;
      end
      else
      begin
         type_prev_q <= type_s;
         if (type_steady)
            type_q <= type_s;
      end
   end

   // control registers
   ess_family_t family_q;
   logic [TYPE_W-1:0] exp_type_q;
   logic [ESS_IRQ_W-1:0] irq_en_q;
   logic [ESS_IRQ_W-1:0] irq_stat_q;

   // family A encoding
   wire logic [7:0] a_lo;
   wire logic [7:0] a_hi;
   assign a_lo = a_s;
   assign a_hi = {2'b00, |a_lo[5:0], a_lo[6] | a_lo[7], 4'h0};

   // family B encoding
   wire logic b_mismatch;
   wire logic [7:0] b_lo;
   wire logic [7:0] b_hi;
   assign b_mismatch = type_q != exp_type_q;
   assign b_lo = {b_s.thermal_alarm, 1'b0, b_s.comm_err, b_s.cpu_mem_err,
                  b_s.cap_photo_err, b_mismatch, b_s.init_err, b_s.over_speed};
   // error summary covers every error bit, alarm summary the thermal alarm
   assign b_hi = {2'b00, |b_lo[5:0], b_lo[7], 4'h0};

   wire ess_status_t status_d;
   assign status_d.lo = (family_q == ESS_FAM_B) ? b_lo : a_lo;
   assign status_d.hi = (family_q == ESS_FAM_B) ? b_hi : a_hi;

   ess_status_t status_q;
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         status_q <= '0;
      else
         status_q <= status_d;
   end
   assign status = status_q;

   // rising edges of the summaries and of the family B mismatch bit raise interrupt events
   wire logic [ESS_IRQ_W-1:0] ev_level;
   logic [ESS_IRQ_W-1:0] ev_prev_q;
   wire logic [ESS_IRQ_W-1:0] ev_pulse;
   assign ev_level[ESS_IRQ_ERR_SUM] = status_q.hi[ESS_HI_ERR_SUM_BIT];
   assign ev_level[ESS_IRQ_ALM_SUM] = status_q.hi[ESS_HI_ALM_SUM_BIT];
   assign ev_level[ESS_IRQ_MISMATCH] = (family_q == ESS_FAM_B) & status_q.lo[ESS_LO_MISMATCH_BIT];
   assign ev_pulse = ev_level & ~ev_prev_q;

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         ev_prev_q <= '0;
      else
         ev_prev_q <= ev_level;
   end

   // write channel
   logic awready_q;
   logic wready_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic aw_hold_q;
   logic w_hold_q;
   logic [ESS_ADDR_W-1:0] waddr_q;
   logic [ESS_DATA_W-1:0] wdata_q;
   logic [3:0] wstrb_q;

   wire logic aw_take;
   wire logic w_take;
   wire logic do_write;
   wire logic aw_hold_d;
   wire logic w_hold_d;
   wire logic bvalid_d;
   assign aw_take = s_axi_awvalid & awready_q;
   assign w_take = s_axi_wvalid & wready_q;
   assign do_write = aw_hold_q & w_hold_q & ~bvalid_q;
   assign aw_hold_d = (aw_hold_q & ~do_write) | aw_take;
   assign w_hold_d = (w_hold_q & ~do_write) | w_take;
   assign bvalid_d = (bvalid_q & ~s_axi_bready) | do_write;

   wire logic wr_ctrl;
   wire logic wr_clr;
   wire logic wr_en;
   wire logic wr_ro;
   assign wr_ctrl = do_write & (waddr_q[7:2] == ESS_OFS_CTRL[7:2]);
   assign wr_clr = do_write & (waddr_q[7:2] == ESS_OFS_IRQ_CLR[7:2]);
   assign wr_en = do_write & (waddr_q[7:2] == ESS_OFS_IRQ_EN[7:2]);
   assign wr_ro = do_write & ((waddr_q[7:2] == ESS_OFS_STATUS[7:2]) | (waddr_q[7:2] == ESS_OFS_IRQ_STAT[7:2]));

   wire logic wr_hit;
   assign wr_hit = wr_ctrl | wr_clr | wr_en | wr_ro;

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         bvalid_q <= 1'b0;
         bresp_q <= ESS_RESP_OKAY;
      end
      else
      begin
         aw_hold_q <= aw_hold_d;
         w_hold_q <= w_hold_d;
         // no new address or data until the response has gone
         awready_q <= ~aw_hold_d & ~bvalid_d;
         wready_q <= ~w_hold_d & ~bvalid_d;
         bvalid_q <= bvalid_d;
         if (do_write)
            bresp_q <= wr_hit ? ESS_RESP_OKAY : ESS_RESP_SLVERR;
      end
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         waddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end
      else
      begin
         if (aw_take)
            waddr_q <= s_axi_awaddr;
         if (w_take)
         begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
      end
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;

   // control register writes honour byte lanes
   wire logic [ESS_IRQ_W-1:0] clr_bits;
   assign clr_bits = (wr_clr & wstrb_q[0]) ? wdata_q[ESS_IRQ_W-1:0] : '0;

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         family_q <= ess_family_t'(ESS_RST_FAMILY);
         exp_type_q <= ESS_RST_EXP_TYPE[TYPE_W-1:0];
         irq_en_q <= ESS_RST_IRQ_EN;
      end
      else
      begin
         if (wr_ctrl & wstrb_q[0])
            family_q <= ess_family_t'(wdata_q[ESS_CTRL_FAMILY_BIT]);
         if (wr_ctrl & wstrb_q[1])
            exp_type_q <= wdata_q[ESS_CTRL_EXP_TYPE_LSB +: TYPE_W];
         if (wr_en & wstrb_q[0])
            irq_en_q <= wdata_q[ESS_IRQ_W-1:0];
      end
   end

   // a new event outranks a clear landing in the same cycle
   wire logic [ESS_IRQ_W-1:0] irq_stat_d;
   assign irq_stat_d = (irq_stat_q & ~clr_bits) | ev_pulse;

   logic irq_q;
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         irq_stat_q <= '0;
         irq_q <= 1'b0;
      end
      else
      begin
         irq_stat_q <= irq_stat_d;
         irq_q <= |(irq_stat_d & irq_en_q);
      end
   end
   assign irq = irq_q;

   // read channel
   logic arready_q;
   logic rvalid_q;
   logic [ESS_DATA_W-1:0] rdata_q;
   logic [1:0] rresp_q;

   wire logic ar_take;
   wire logic rvalid_d;
   assign ar_take = s_axi_arvalid & arready_q;
   assign rvalid_d = (rvalid_q & ~s_axi_rready) | ar_take;

   wire logic rd_ctrl;
   wire logic rd_stat;
   wire logic rd_irq;
   wire logic rd_en;
   wire logic rd_clr;
   assign rd_ctrl = s_axi_araddr[7:2] == ESS_OFS_CTRL[7:2];
   assign rd_stat = s_axi_araddr[7:2] == ESS_OFS_STATUS[7:2];
   assign rd_irq = s_axi_araddr[7:2] == ESS_OFS_IRQ_STAT[7:2];
   assign rd_en = s_axi_araddr[7:2] == ESS_OFS_IRQ_EN[7:2];
   assign rd_clr = s_axi_araddr[7:2] == ESS_OFS_IRQ_CLR[7:2];

   wire logic [ESS_DATA_W-1:0] ctrl_word;
   wire logic [ESS_DATA_W-1:0] stat_word;
   wire logic [ESS_DATA_W-1:0] rdata_d;
   assign ctrl_word = ESS_DATA_W'({exp_type_q, 7'h00, family_q});
   assign stat_word = ESS_DATA_W'({type_q, status_q.hi, status_q.lo});
   // the clear register is write-only and reads as zero
   assign rdata_d = rd_ctrl ? ctrl_word :
                    rd_stat ? stat_word :
                    rd_irq ? ESS_DATA_W'(irq_stat_q) :
                    rd_en ? ESS_DATA_W'(irq_en_q) : '0;

   wire logic rd_hit;
   assign rd_hit = rd_ctrl | rd_stat | rd_irq | rd_en | rd_clr;

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= ESS_RESP_OKAY;
      end
      else
      begin
         arready_q <= ~rvalid_d;
         rvalid_q <= rvalid_d;
         if (ar_take)
         begin
            rdata_q <= rdata_d;
            rresp_q <= rd_hit ? ESS_RESP_OKAY : ESS_RESP_SLVERR;
         end
      end
   end

   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

endmodule

// file: tb/ess_encoder_props.sv
// assertions on the status encoder ports
// assumes the bind below and a single clock domain
`timescale 1ns/1ps
module ess_encoder_props
   import ess_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire ess_status_t status,
   input wire logic irq,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);

   a_hi_spare_zero: assert property ({status.hi[7:6], status.hi[3:0]} == 6'h00)
      else $error("spare high status bits set");
   a_err_summary: assert property (status.hi[5] == |status.lo[5:0])
      else $error("error summary wrong");
   a_alarm_summary: assert property (status.hi[4] == (status.lo[6] | status.lo[7]))
      else $error("alarm summary wrong");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answering");

   c_irq: cover property (irq);
   c_err_sum: cover property (status.hi[5]);
   c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind ess_encoder ess_encoder_props u_props (.mclk, .reset, .status, .irq, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

// file: tb/ess_host_model.sv
// host side: latches both status bytes as a status reply carries them
// assumes sample is a one-cycle strobe from the bench
`timescale 1ns/1ps
module ess_host_model
   import ess_pkg::*;
(
   input wire logic mclk,
   input wire logic sample,
   input wire ess_status_t status,
   output logic [15:0] rx
);
   always_ff @(posedge mclk)
   begin
      if (sample)
         rx <= {status.hi, status.lo};
   end
endmodule

// file: tb/ess_encoder_test.sv
// bench for the status encoder: family maps, summaries, interrupt, bus
// assumes the host model captures the status bytes on request
`timescale 1ns/1ps
module ess_encoder_test;
   import ess_pkg::*;
   logic mclk = 1'b0, reset = 1'b1, sample = 1'b0;
   ess_fam_a_flags_t fam_a_flags = '0;
   ess_fam_b_flags_t fam_b_flags = '0;
   logic [7:0] enc_type = 8'h00, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, v;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp, r, wresp;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic [15:0] rx;
   ess_status_t status;
   int err_total = 0, total_checks = 0, cyc = 0;

   always #2.5 mclk = ~mclk;

   ess_encoder u_dut (.mclk, .reset, .fam_a_flags, .fam_b_flags, .enc_type, .status, .irq, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   ess_host_model u_host (.mclk, .sample, .status, .rx);

   task automatic report_and_stop;
      if (err_total == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_total++;
         report_and_stop;
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] dat);
      s_axi_awaddr <= a;
      s_axi_wdata <= dat;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      // the loop test sees values before this step's updates land, so wait an edge first
      do
      begin
         @(posedge mclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bready && s_axi_bvalid)
         begin
            s_axi_bready <= 1'b0;
            wresp = s_axi_bresp;
         end
      end
      while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
   endtask

   task automatic rd(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge mclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rready && s_axi_rvalid)
         begin
            s_axi_rready <= 1'b0;
            d = s_axi_rdata;
            r = s_axi_rresp;
         end
      end
      while (s_axi_arvalid || s_axi_rready);
   endtask

   // flags reach status in three edges, the type code in five; one spare
   task automatic look(input logic [15:0] exp);
      repeat (6) @(posedge mclk);
      sample <= 1'b1;
      @(posedge mclk);
      sample <= 1'b0;
      @(posedge mclk);
      chk(rx, exp);
   endtask

   task automatic sc_fam_a;
      wr(ESS_OFS_CTRL, 32'h0);
      fam_b_flags <= '1;
      for (int i = 0; i <= 8; i++)
      begin
         v = 8'h01 << i;
         fam_a_flags <= v;
         look({2'b00, |v[5:0], v[6] | v[7], 4'h0, v});
      end
   endtask

   task automatic sc_fam_b;
      wr(ESS_OFS_CTRL, 32'h5a01);
      enc_type <= 8'h5a;
      fam_a_flags <= '1;
      for (int i = 0; i <= 6; i++)
      begin
         v = 8'h01 << i;
         fam_b_flags <= v[5:0];
         look({2'b00, |v[4:0], v[5], 4'h0, v[5], 1'b0, v[4:2], 1'b0, v[1:0]});
      end
      wr(ESS_OFS_IRQ_CLR, 32'h7);
      enc_type <= 8'h5b;
      look(16'h2004);
      rd(ESS_OFS_STATUS);
      chk(d, 32'h005b2004);
      rd(ESS_OFS_IRQ_STAT);
      chk(d, 32'h5);
   endtask

   task automatic sc_irq;
      rd(ESS_OFS_IRQ_EN);
      chk(d, 32'h0);
      wr(ESS_OFS_CTRL, 32'h0);
      fam_a_flags <= '0;
      look(16'h0000);
      wr(ESS_OFS_IRQ_CLR, 32'h7);
      wr(ESS_OFS_IRQ_EN, 32'h1);
      fam_a_flags <= 8'h01;
      look(16'h2001);
      chk(irq, 1);
      rd(ESS_OFS_IRQ_STAT);
      chk(d, 32'h1);
      fam_a_flags <= '0;
      wr(ESS_OFS_IRQ_CLR, 32'h1);
      repeat (2) @(posedge mclk);
      chk(irq, 0);
      // alarm summary is not enabled, so it must stay quiet
      fam_a_flags <= 8'h80;
      look(16'h1080);
      chk(irq, 0);
      rd(ESS_OFS_IRQ_STAT);
      chk(d, 32'h2);
      rd(8'h20);
      chk(d, 32'h0);
      chk(32'(r), 32'(ESS_RESP_SLVERR));
      wr(8'h20, 32'h1);
      chk(32'(wresp), 32'(ESS_RESP_SLVERR));
      // only byte 0 enabled: family follows, expected type must not
      s_axi_wstrb <= 4'h1;
      wr(ESS_OFS_CTRL, 32'h7701);
      chk(32'(wresp), 32'(ESS_RESP_OKAY));
      s_axi_wstrb <= 4'hf;
      rd(ESS_OFS_CTRL);
      chk(d, 32'h1);
   endtask

   initial
   begin
      repeat (12) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      sc_fam_a;
      sc_fam_b;
      sc_irq;
      report_and_stop;
   end
endmodule
